//--- src/fdol_pkg.sv
/*
  package for the floppy drive option logic: register indices, byte addresses,
  field positions, reset values and the pin bundle type.
  assumes a 32-bit apb bus with one register per aligned word.
*/
package fdol_pkg;

  // register indices and byte addresses
  localparam logic [11:0] TYPE_INDEX     = 12'h0F2;
  localparam logic [11:0] DISABLE_INDEX  = 12'h0F0;
  localparam logic [11:0] OPTION_INDEX   = 12'h0F1;
  localparam logic [11:0] STATUS_INDEX   = 12'h0F3;
  localparam logic [11:0] TYPE_ADDR      = {TYPE_INDEX[9:0], 2'b00};
  localparam logic [11:0] DISABLE_ADDR   = {DISABLE_INDEX[9:0], 2'b00};
  localparam logic [11:0] OPTION_ADDR    = {OPTION_INDEX[9:0], 2'b00};
  localparam logic [11:0] STATUS_ADDR    = {STATUS_INDEX[9:0], 2'b00};

  // field positions
  localparam int          FORCE_WP_BIT   = 0;
  localparam int          DENSITY_LSB    = 2;
  localparam int          DISABLE_WP_BIT = 0;
  localparam int          STATUS_WP_BIT  = 1;

  // writable masks, reserved positions stay zero
  localparam logic [7:0]  OPTION_MASK    = 8'h0D;
  localparam logic [7:0]  DISABLE_MASK   = 8'h01;

  // reset values
  localparam logic [7:0]  TYPE_RESET     = 8'hFF;
  localparam logic [7:0]  OPTION_RESET   = 8'h00;
  localparam logic [7:0]  DISABLE_RESET  = 8'h00;

  // density select codes
  localparam logic [1:0]  DENS_NORMAL    = 2'h0;
  localparam logic [1:0]  DENS_USER      = 2'h1;
  localparam logic [1:0]  DENS_FORCE1    = 2'h2;
  localparam logic [1:0]  DENS_FORCE0    = 2'h3;

  // boot drive number
  localparam logic        BOOT_DRIVE     = 1'b0;

  // one floppy drive path, active low pins
  typedef struct packed {
    logic driveSelectZeroN;
    logic driveSelectOneN;
    logic writeProtectLineN;
  } fdol_drive_pins_type;

endpackage : fdol_pkg

//--- src/fdol_drive_option.sv
/*
  floppy drive option logic: write-protect combining, density override,
  drive type storage, apb register slave.
  assumes drive pins arrive asynchronously; core density and apb on sys_clk.
*/
// The implementer's own choice: the APB slave port.
//////////////////////////////////////////////////////////////////////////////
// Operation
// R01: core write protect = ds0&force | ds1&force | drive line | global bit.
// R02: drive interface write-protect line is one term of the combined value.
// R03: combined write-protect value readable in status register A bit 1.
// R04: global write-protect bit lives in device-disable register, not option.
// R05: boot drive is always drive 0, never drive 1.
// R06: forced write protect also applies to the parallel-port floppy path.
// R07: density bits 3:2: 00/01 normal, 10 forces 1, 11 forces 0.
// R08: option register bit 1 and bits 7:4 are reserved, no function.
// R09: read/write drive type register at 0xF2, A in 1:0, B in 3:2.
// R10: type bits 5:4 reserved, storage only, no effect on behaviour.
// R11: drive type register loads 0xFF on every reset.
// R12: writes to reserved bits ignored, no effect on outputs or write protect.
//////////////////////////////////////////////////////////////////////////////
module fdol_drive_option (
  // clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          reset_n,
  // apb slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [11:0]                   paddr,
  input  wire logic [31:0]                   pwdata,
  input  wire logic [3:0]                    pstrb,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  // drive interface and parallel-port floppy path pins
  input  wire fdol_pkg::fdol_drive_pins_type drivePins,
  input  wire fdol_pkg::fdol_drive_pins_type portPins,
  // controller core side
  input  wire logic                          coreDensity,
  output logic                               coreWriteProtect,
  output logic                               portWriteProtect,
  output logic                               densitySelect,
  output logic                               bootDriveSelect,
  output logic      [1:0]                    driveTypeA,
  output logic      [1:0]                    driveTypeB
);

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  fdol_pkg::fdol_drive_pins_type driveMeta_q;
  fdol_pkg::fdol_drive_pins_type driveSync_q;
  fdol_pkg::fdol_drive_pins_type portMeta_q;
  fdol_pkg::fdol_drive_pins_type portSync_q;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      driveMeta_q <= 3'h7;
      driveSync_q <= 3'h7;
      portMeta_q  <= 3'h7;
      portSync_q  <= 3'h7;
    end else begin
      driveMeta_q <= drivePins;
      driveSync_q <= driveMeta_q;
      portMeta_q  <= portPins;
      portSync_q  <= portMeta_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] type_q;
  logic [7:0] option_q;
  logic [7:0] disable_q;
  logic       coreWp_q;
  logic       portWp_q;
  logic       density_q;
  logic       boot_q;
  logic [31:0] rdata_q;

  wire        setupPhase  = psel & ~penable;
  wire        writeTaken  = psel & penable & pwrite & pstrb[0];
  wire        hitType     = (paddr == fdol_pkg::TYPE_ADDR);
  wire        hitOption   = (paddr == fdol_pkg::OPTION_ADDR);
  wire        hitDisable  = (paddr == fdol_pkg::DISABLE_ADDR);
  wire        hitStatus   = (paddr == fdol_pkg::STATUS_ADDR);
  wire        hitAny      = hitType | hitOption | hitDisable | hitStatus;
  wire        forceWp     = option_q[fdol_pkg::FORCE_WP_BIT];
  wire        globalWp    = disable_q[fdol_pkg::DISABLE_WP_BIT];                  // [R04]
  wire [1:0]  densityCode = option_q[fdol_pkg::DENSITY_LSB +: 2];

  // combined write protect per path
  wire        coreWp_d    = (~driveSync_q.driveSelectZeroN & forceWp)             // [R01]
                          | (~driveSync_q.driveSelectOneN & forceWp)
                          | ~driveSync_q.writeProtectLineN                       // [R02]
                          | globalWp;
  wire        portWp_d    = (~portSync_q.driveSelectZeroN & forceWp)              // [R06]
                          | (~portSync_q.driveSelectOneN & forceWp)
                          | ~portSync_q.writeProtectLineN
                          | globalWp;

  // density override
  wire        density_d   = (densityCode == fdol_pkg::DENS_FORCE1) ? 1'b1 :      // [R07]
                            (densityCode == fdol_pkg::DENS_FORCE0) ? 1'b0 :
                            coreDensity;

  // status register a image
  wire [7:0]  statusA     = 8'(coreWp_q) << fdol_pkg::STATUS_WP_BIT;             // [R03]

  wire [7:0]  readByte    = hitType    ? type_q    :
                            hitOption  ? option_q  :
                            hitDisable ? disable_q :
                            hitStatus  ? statusA   : 8'h00;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      type_q    <= fdol_pkg::TYPE_RESET;                                       // [R11]
      option_q  <= fdol_pkg::OPTION_RESET;
      disable_q <= fdol_pkg::DISABLE_RESET;
    end else if (writeTaken) begin
      if (hitType) begin
        type_q <= pwdata[7:0];                                                 // [R09] [R10]
      end
      if (hitOption) begin
        option_q <= pwdata[7:0] & fdol_pkg::OPTION_MASK;                       // [R08] [R12]
      end
      if (hitDisable) begin
        disable_q <= pwdata[7:0] & fdol_pkg::DISABLE_MASK;                     // [R12]
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      coreWp_q  <= 1'b0;
      portWp_q  <= 1'b0;
      density_q <= 1'b0;
      boot_q    <= fdol_pkg::BOOT_DRIVE;
      rdata_q   <= 32'h0000_0000;
    end else begin
      coreWp_q  <= coreWp_d;
      portWp_q  <= portWp_d;
      density_q <= density_d;
      boot_q    <= fdol_pkg::BOOT_DRIVE;                                       // [R05]
      if (setupPhase) begin
        rdata_q <= {24'h00_0000, readByte};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs
  assign pready           = 1'b1;
  assign pslverr          = psel & penable & ~hitAny;
  assign prdata           = rdata_q;
  assign coreWriteProtect = coreWp_q;
  assign portWriteProtect = portWp_q;
  assign densitySelect    = density_q;
  assign bootDriveSelect  = boot_q;
  assign driveTypeA       = type_q[1:0];                                       // [R09]
  assign driveTypeB       = type_q[3:2];

  //////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  sequence s_write_type;
    psel & penable & pwrite & pstrb[0] & hitType;
  endsequence

  sequence s_read_status;
    psel & ~penable & ~pwrite & hitStatus ##1 psel & penable;
  endsequence

  sequence s_read_type;
    psel & ~penable & ~pwrite & hitType ##1 psel & penable;
  endsequence

  sequence s_read_option;
    psel & ~penable & ~pwrite & hitOption ##1 psel & penable;
  endsequence

  sequence s_type_idle;
    !(psel & penable & pwrite & pstrb[0] & hitType);
  endsequence

  a_core_wp_combine: assert property (                                         // [R01]
    ##1 coreWriteProtect == ((~$past(driveSync_q.driveSelectZeroN) & $past(forceWp))
                          | (~$past(driveSync_q.driveSelectOneN) & $past(forceWp))
                          | ~$past(driveSync_q.writeProtectLineN) | $past(globalWp)))
    else $error("core write protect mismatch");

  a_wp_line_pass: assert property (                                            // [R02]
    !drivePins.writeProtectLineN [*3] |=> coreWriteProtect)
    else $error("drive write protect line not passed");

  a_status_wp_bit: assert property (                                           // [R03]
    s_read_status |-> prdata[1] == $past(coreWriteProtect))
    else $error("status bit 1 does not show write protect");

  a_global_wp: assert property (                                               // [R04]
    globalWp |=> coreWriteProtect && portWriteProtect)
    else $error("global write protect ignored");

  a_boot_drive: assert property (bootDriveSelect == 1'b0)                       // [R05]
    else $error("boot drive not zero");

  a_port_force: assert property (                                              // [R06]
    forceWp && !portSync_q.driveSelectOneN |=> portWriteProtect)
    else $error("forced protect missing on port path");

  a_density_force: assert property (                                           // [R07]
    densityCode == fdol_pkg::DENS_FORCE1 |=> densitySelect == 1'b1 ##0
    $past(densityCode) != fdol_pkg::DENS_FORCE0)
    else $error("density not forced to one");

  a_density_zero: assert property (                                            // [R07]
    densityCode == fdol_pkg::DENS_FORCE0 |=> !densitySelect)
    else $error("density not forced to zero");

  a_density_normal: assert property (                                          // [R07]
    densityCode[1] == 1'b0 |=> densitySelect == $past(coreDensity))
    else $error("density not passed in normal mode");

  a_option_reserved: assert property ((option_q & ~fdol_pkg::OPTION_MASK) == 8'h00) // [R08]
    else $error("reserved option bits set");

  a_type_write: assert property (                                              // [R09]
    s_write_type |=> type_q == $past(pwdata[7:0]) ##1 driveTypeB == type_q[3:2])
    else $error("drive type write lost");

  a_type_reserved: assert property (                                           // [R10]
    s_write_type ##0 pwdata[3:0] == type_q[3:0] |=> $stable({driveTypeB, driveTypeA}))
    else $error("reserved type bits changed drive types");

  a_type_reset: assert property (                                              // [R11]
    $rose(reset_n) |-> type_q == fdol_pkg::TYPE_RESET)
    else $error("drive type reset value wrong");

  a_reserved_write: assert property (                                          // [R12]
    psel & penable & pwrite & hitOption & pstrb[0] |=> option_q ==
    ($past(pwdata[7:0]) & fdol_pkg::OPTION_MASK))
    else $error("reserved write had effect");

  a_port_wp_combine: assert property (                                         // [R06]
    ##1 portWriteProtect == ((~$past(portSync_q.driveSelectZeroN) & $past(forceWp))
                          | (~$past(portSync_q.driveSelectOneN) & $past(forceWp))
                          | ~$past(portSync_q.writeProtectLineN) | $past(globalWp)))
    else $error("port write protect mismatch");

  a_core_wp_clear: assert property (                                           // [R01]
    driveSync_q.writeProtectLineN && !forceWp && !globalWp |=> !coreWriteProtect)
    else $error("core write protect set with no term");

  a_port_wp_clear: assert property (                                           // [R06]
    portSync_q.writeProtectLineN && !forceWp && !globalWp |=> !portWriteProtect)
    else $error("port write protect set with no term");

  a_force_sel_zero: assert property (                                          // [R01]
    forceWp && !driveSync_q.driveSelectZeroN |=> coreWriteProtect)
    else $error("forced protect missing on drive select zero");

  a_force_sel_one: assert property (                                           // [R01]
    forceWp && !driveSync_q.driveSelectOneN |=> coreWriteProtect)
    else $error("forced protect missing on drive select one");

  a_port_force_zero: assert property (                                         // [R06]
    forceWp && !portSync_q.driveSelectZeroN |=> portWriteProtect)
    else $error("forced protect missing on port select zero");

  a_port_line_pass: assert property (                                          // [R06]
    !portSync_q.writeProtectLineN |=> portWriteProtect)
    else $error("port write protect line not passed");

  a_sync_chain: assert property (                                              // [R02]
    driveSync_q == $past(driveMeta_q))
    else $error("drive pin synchroniser skipped a stage");

  a_port_sync_chain: assert property (                                         // [R06]
    portSync_q == $past(portMeta_q))
    else $error("port pin synchroniser skipped a stage");

  a_disable_reserved: assert property ((disable_q & ~fdol_pkg::DISABLE_MASK) == 8'h00) // [R12]
    else $error("reserved disable bits set");

  a_type_hold: assert property (                                               // [R09]
    s_type_idle |=> $stable(type_q))
    else $error("drive type changed without a write");

  a_pstrb_gate: assert property (                                              // [R09]
    psel & penable & pwrite & ~pstrb[0] |=> $stable({type_q, option_q, disable_q}))
    else $error("write without lane zero strobe landed");

  a_read_type: assert property (                                               // [R09]
    s_read_type |-> prdata == {24'h00_0000, $past(type_q)})
    else $error("drive type read back wrong");

  a_read_option: assert property (                                             // [R08]
    s_read_option |-> (prdata[7:0] & ~fdol_pkg::OPTION_MASK) == 8'h00)
    else $error("reserved option bits read back set");

  a_density_user: assert property (                                            // [R07]
    densityCode == fdol_pkg::DENS_USER |=> densitySelect == $past(coreDensity))
    else $error("density not passed for user code");

  a_status_upper: assert property (                                            // [R03]
    s_read_status |-> (prdata & ~32'h0000_0002) == 32'h0000_0000)
    else $error("status read shows stray bits");

endmodule : fdol_drive_option

//--- sim/fdol_drive_model.sv
/*
  behavioural floppy drive seen from the option logic pins.
  assumes the bench sets select and protect levels with nonblocking writes just after a rising clock edge.
*/
module fdol_drive_model (
  // drive state, active high
  input  wire logic                     selZero,
  input  wire logic                     selOne,
  input  wire logic                     protect,
  // pins toward the block, active low
  output fdol_pkg::fdol_drive_pins_type pins
);
  timeunit 1ns;
  timeprecision 1ps;
  // drive side holds its levels, no clock
  assign pins.driveSelectZeroN  = ~selZero;
  assign pins.driveSelectOneN   = ~selOne;
  assign pins.writeProtectLineN = ~protect;
endmodule : fdol_drive_model

//--- sim/tb.sv
/*
  self-checking bench for the floppy drive option logic.
  assumes zero wait apb slave and two drive models on the pin side.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk, reset_n, psel, penable, pwrite, pready, pslverr;
  logic        coreDensity, coreWriteProtect, portWriteProtect, densitySelect;
  logic        bootDriveSelect, selZero, selOne, protect, portProtect, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [3:0]  pstrb;
  logic [1:0]  driveTypeA, driveTypeB;
  int          failures, comparisons, cycles;
  fdol_pkg::fdol_drive_pins_type drivePins, portPins;
  //////////////////////////////////////////////////////////////////////////
  fdol_drive_option i_fdol_drive_option (.sys_clk(sys_clk), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .drivePins(drivePins), .portPins(portPins),
    .coreDensity(coreDensity), .coreWriteProtect(coreWriteProtect),
    .portWriteProtect(portWriteProtect), .densitySelect(densitySelect),
    .bootDriveSelect(bootDriveSelect), .driveTypeA(driveTypeA),
    .driveTypeB(driveTypeB));
  fdol_drive_model i_fdol_drive_model (.selZero(selZero), .selOne(selOne),
    .protect(protect), .pins(drivePins));
  fdol_drive_model i_fdol_port_model (.selZero(selZero), .selOne(selOne),
    .protect(portProtect), .pins(portPins));
  //////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      final_report();
    end
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic test_type;
    check({24'h0, rdata[7:0]}, 32'hFF);
    apb(1'b1, fdol_pkg::TYPE_ADDR, 32'hA6);
    apb(1'b0, fdol_pkg::TYPE_ADDR, 32'h0);
    check(rdata, 32'hA6);
    repeat (2) @(posedge sys_clk);
    check({28'h0, driveTypeB, driveTypeA}, 32'h6);
    apb(1'b1, fdol_pkg::TYPE_ADDR, 32'hF6);
    apb(1'b0, fdol_pkg::TYPE_ADDR, 32'h0);
    check({rdata[7:0], 2'b0, driveTypeB, driveTypeA}, 32'h3D86);
    pstrb <= 4'h0;
    apb(1'b1, fdol_pkg::TYPE_ADDR, 32'h11);
    pstrb <= 4'hF;
    apb(1'b0, fdol_pkg::TYPE_ADDR, 32'h0);
    check(rdata, 32'hF6);
    $display("test type done");
  endtask : test_type
  task automatic test_protect;
    logic e;
    logic ep;
    for (int i = 0; i < 32; i++) begin
      apb(1'b1, fdol_pkg::OPTION_ADDR, {31'h0, i[0]});
      apb(1'b1, fdol_pkg::DISABLE_ADDR, {31'h0, i[1]});
      selZero <= i[2];
      selOne <= i[3];
      protect <= i[4];
      portProtect <= ~i[4];
      repeat (5) @(posedge sys_clk);
      e = (i[2] & i[0]) | (i[3] & i[0]) | i[4] | i[1];
      ep = (i[2] & i[0]) | (i[3] & i[0]) | ~i[4] | i[1];
      check({31'h0, coreWriteProtect}, {31'h0, e});
      check({31'h0, portWriteProtect}, {31'h0, ep});
      apb(1'b0, fdol_pkg::STATUS_ADDR, 32'h0);
      check({30'h0, rdata[1], 1'b0}, {30'h0, e, 1'b0});
    end
    $display("test protect done");
  endtask : test_protect
  task automatic test_density;
    logic e;
    selZero <= 1'b1;
    selOne <= 1'b0;
    protect <= 1'b0;
    apb(1'b1, fdol_pkg::DISABLE_ADDR, 32'h0);
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, fdol_pkg::OPTION_ADDR, {28'h0, c[2:1], 2'b00});
      coreDensity <= c[0];
      repeat (3) @(posedge sys_clk);
      e = (c[2:1] == 2'b10) ? 1'b1 : (c[2:1] == 2'b11) ? 1'b0 : c[0];
      check({31'h0, densitySelect}, {31'h0, e});
    end
    apb(1'b1, fdol_pkg::OPTION_ADDR, 32'hF2);
    apb(1'b0, fdol_pkg::OPTION_ADDR, 32'h0);
    repeat (5) @(posedge sys_clk);
    check({rdata[7:0], 7'h0, coreWriteProtect}, 32'h0);
    $display("test density done");
  endtask : test_density
  task automatic test_misc;
    apb(1'b0, 12'h100, 32'h0);
    check({rdata[7:0], 7'h0, err}, 32'h1);
    check({31'h0, bootDriveSelect}, 32'h0);
    reset_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    apb(1'b0, fdol_pkg::TYPE_ADDR, 32'h0);
    check(rdata, 32'hFF);
    $display("test misc done");
  endtask : test_misc
  //////////////////////////////////////////////////////////////////////////
  initial begin
    {reset_n, psel, penable, pwrite, coreDensity, selZero, selOne, protect, portProtect} = '0;
    {paddr, pwdata, rdata, err, failures, comparisons, cycles} = '0;
    pstrb = 4'hF;
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    apb(1'b0, fdol_pkg::TYPE_ADDR, 32'h0);
    test_type();
    test_protect();
    test_density();
    test_misc();
    final_report();
  end
endmodule : tb
